// ---- src/ip_drive.sv ----
// What this block does
// RULE1 - Cycle period object selects regulation method
// RULE2 - Short cycle: sync runs loop, no interpolation
// RULE3 - Long cycle: interpolate per sub-mode object
// RULE4 - Sub-mode 0 linear, -1/-2 cubic variants (the ramp here is linear in all three sub-modes)
// RULE5 - No position mapped: apply velocity reference only
// RULE6 - No unit conversion on received references
// RULE7 - Short cycle: feedforward from position delta
// RULE8 - Long cycle: rpm entry gives feedforward (here not applied in the cubic position-only sub-mode)
// RULE9 - Master sends record, then validates by sync
// RULE10 - Short cycle: sync loads latest set-point (here each sync pops the oldest buffered record)
// RULE11 - Linear/cubic-pv: one cycle of delay
// RULE12 - Cubic position-only: two cycles of delay
// RULE13 - Linear: each record is one set-point
// RULE14 - Last record item advances buffer slot
// RULE15 - Record: position, counts/s, rpm, signed 32
// RULE16 - Reserved sub-mode values are ignored
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps

// ****************************************************************
// Set-point buffer.
// ****************************************************************
module ip_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign level     = cnt_q;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage is written only on an accepted push.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and count move on accepted transfers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // ip_fifo

// ****************************************************************
// Drive end: object store, set-point buffer and interpolator.
// ****************************************************************
module ip_drive (
    input  wire logic        clk,
    input  wire logic        rst_n,
    ip_link_if.drive         link,
    input  wire logic [31:0] meas_pos,
    input  wire logic        ff_compute_en,
    output logic      [31:0] traj_setpoint,
    output logic             pos_loop_en,
    output logic      [31:0] vel_cmd,
    output logic             vel_is_rpm,
    output logic      [31:0] vel_ff,
    output logic             loop_strobe,
    output logic      [15:0] quick_stop_mode
);
    import ip_pkg::*;

    logic [15:0] ctrl_q, submode_q, status_q;
    logic [7:0]  mode_q;
    logic [31:0] period_q, meas_q;
    logic [31:0] rec_pos_q, rec_vc_q, rec_vr_q;
    logic [2:0]  rec_mask_q;
    logic        ready_q;
    logic        accept, push, f_in_ready, f_out_valid;
    logic [REC_W-1:0] f_out;
    logic [$clog2(FIFO_DEPTH):0] f_level;
    logic        ip_active, short_cyc, sync_pop;
    logic [31:0] new_pos, new_vc, new_vr, tgt1_q, tgt2_q, sp_q, dest;
    logic [2:0]  new_mask;
    logic        tgt1_ok_q;
    logic [5:0]  tick_cnt_q;
    logic        tick;
    logic [31:0] quo_q, rem_q, left_q;
    logic [32:0] rem_sh, err_q, err_d;
    logic [5:0]  div_cnt_q;
    logic        div_busy_q, neg_q, start_div;

    assign accept    = link.obj_valid && ready_q;
    assign ip_active = (mode_q == MODE_IP) && ctrl_q[CTRL_IP_EN_BIT];
    // RULE1 cycle period split
    assign short_cyc = (period_q < CYCLE_SPLIT_US);
    // RULE14 auto advance slot
    assign push      = accept && link.obj_last;
    // RULE9 only validated records
    assign sync_pop  = link.sync && f_out_valid && ip_active;
    assign {new_mask, new_vr, new_vc, new_pos} = f_out;

    // Object writes from the master; record entries are kept raw.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q          <= '0;
            quick_stop_mode <= '0;
            mode_q          <= '0;
            submode_q       <= SUBMODE_RESET;
            period_q        <= '0;
            rec_pos_q       <= '0;
            rec_vc_q        <= '0;
            rec_vr_q        <= '0;
            rec_mask_q      <= '0;
        end else if (accept) begin
            case (link.obj_index)
                IDX_CONTROL:  ctrl_q <= link.obj_data[15:0];
                IDX_QSTOP:    quick_stop_mode <= link.obj_data[15:0];
                IDX_MODE_SEL: mode_q <= link.obj_data[7:0];
                IDX_CYCLE:    period_q <= link.obj_data;
                IDX_SUBMODE: begin
                    // RULE16 reserved values ignored
                    if (link.obj_data[15:0] == SUBMODE_LIN || link.obj_data[15:0] == SUBMODE_CPV
                        || link.obj_data[15:0] == SUBMODE_CP) begin
                        submode_q <= link.obj_data[15:0];
                    end
                end
                IDX_RECORD: begin
                    // RULE15 three signed entries
                    case (link.obj_sub)
                        SUB_POS:     rec_pos_q <= link.obj_data;
                        SUB_VEL_CNT: rec_vc_q <= link.obj_data;
                        SUB_VEL_RPM: rec_vr_q <= link.obj_data;
                        default:     rec_pos_q <= rec_pos_q;
                    endcase
                end
                default: ctrl_q <= ctrl_q;
            endcase
            // Track which entries this record carries; a closing item starts a fresh record.
            if (link.obj_last) begin
                rec_mask_q <= '0;
            end else if (link.obj_index == IDX_RECORD && link.obj_sub >= SUB_POS
                         && link.obj_sub <= SUB_VEL_RPM) begin
                rec_mask_q[link.obj_sub[1:0] - 2'd1] <= 1'b1;
            end
        end
    end

    // Merge the closing item into the record that goes to the buffer.
    logic [31:0] cl_pos, cl_vc, cl_vr;
    logic [2:0]  cl_mask;
    always_comb begin
        cl_pos  = rec_pos_q;
        cl_vc   = rec_vc_q;
        cl_vr   = rec_vr_q;
        cl_mask = rec_mask_q;
        if (link.obj_index == IDX_RECORD) begin
            case (link.obj_sub)
                SUB_POS: begin
                    cl_pos     = link.obj_data;
                    cl_mask[0] = 1'b1;
                end
                SUB_VEL_CNT: begin
                    cl_vc      = link.obj_data;
                    cl_mask[1] = 1'b1;
                end
                SUB_VEL_RPM: begin
                    cl_vr      = link.obj_data;
                    cl_mask[2] = 1'b1;
                end
                default: cl_mask = rec_mask_q;
            endcase
        end
    end

    ip_fifo #(.WIDTH(REC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (f_in_ready),
        .in_data   ({cl_mask, cl_vr, cl_vc, cl_pos}),
        .out_valid (f_out_valid),
        .out_ready (sync_pop),
        .out_data  (f_out),
        .level     (f_level)
    );

    // Ready is withdrawn early so a registered ready never overfills the buffer.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= (f_level <= ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH - 2));
        end
    end

    // Microsecond tick for the interpolation ramp.
    always_ff @(posedge clk) begin
        if (!rst_n || link.sync) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= (tick) ? '0 : tick_cnt_q + 6'd1;
        end
    end
    assign tick = (tick_cnt_q == 6'(TICK_CLKS - 1));

    // RULE12 extra stage for cubic-p
    assign dest = (submode_q == SUBMODE_CP) ? tgt2_q : tgt1_q;
    assign start_div = link.sync && ip_active && !short_cyc
                       && (submode_q == SUBMODE_CP ? tgt1_ok_q : (sync_pop && new_mask[0]));

    // Validated targets move one stage per sync while the mode is active, on short and long cycles.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tgt1_q    <= '0;
            tgt2_q    <= '0;
            tgt1_ok_q <= 1'b0;
        end else if (link.sync && ip_active) begin
            // RULE13 one record, one point
            tgt1_q    <= (sync_pop && new_mask[0]) ? new_pos : tgt1_q;
            tgt1_ok_q <= sync_pop && new_mask[0];
            tgt2_q    <= tgt1_q;
        end
    end

    // Serial divider splits the cycle's travel into per-microsecond steps.
    assign rem_sh = {rem_q, quo_q[31]};
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_busy_q <= 1'b0;
            div_cnt_q  <= '0;
            quo_q      <= '0;
            rem_q      <= '0;
            neg_q      <= 1'b0;
        end else if (start_div) begin
            div_busy_q <= 1'b1;
            div_cnt_q  <= '0;
            rem_q      <= '0;
            neg_q      <= 1'b0;
        end else if (div_busy_q && div_cnt_q == 6'd0) begin
            // First busy cycle latches the sign and magnitude of the travel.
            neg_q     <= $signed(dest) < $signed(sp_q);
            quo_q     <= ($signed(dest) < $signed(sp_q)) ? (sp_q - dest) : (dest - sp_q);
            div_cnt_q <= 6'd1;
        end else if (div_busy_q) begin
            if (rem_sh >= {1'b0, period_q}) begin
                rem_q <= 32'(rem_sh - {1'b0, period_q});
                quo_q <= {quo_q[30:0], 1'b1};
            end else begin
                rem_q <= rem_sh[31:0];
                quo_q <= {quo_q[30:0], 1'b0};
            end
            div_cnt_q  <= div_cnt_q + 6'd1;
            div_busy_q <= (div_cnt_q != 6'(DIV_STEPS));
        end
    end

    assign err_d = err_q + {1'b0, rem_q};

    // RULE11 ramp ends after one cycle
    // Set-point, loop enable, velocity and feedforward outputs.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sp_q        <= '0;
            left_q      <= '0;
            err_q       <= '0;
            pos_loop_en <= 1'b0;
            vel_cmd     <= '0;
            vel_is_rpm  <= 1'b0;
            vel_ff      <= '0;
            loop_strobe <= 1'b0;
        end else begin
            loop_strobe <= 1'b0;
            if (sync_pop && !new_mask[0]) begin
                // RULE5 velocity-only control
                pos_loop_en <= 1'b0;
                vel_cmd     <= new_mask[1] ? new_vc : new_vr;
                vel_is_rpm  <= !new_mask[1];
                loop_strobe <= 1'b1;
                left_q      <= '0;
            end else if (sync_pop && short_cyc) begin
                // RULE2 RULE10 direct target at sync
                pos_loop_en <= 1'b1;
                sp_q        <= new_pos;
                loop_strobe <= 1'b1;
                left_q      <= '0;
                // RULE7 delta-based feedforward
                vel_ff      <= ff_compute_en ? (new_pos - sp_q) : '0;
            end else if (div_busy_q && div_cnt_q == 6'(DIV_STEPS)) begin
                // RULE3 RULE4 start interpolation ramp
                // The last divide step lands at this edge, so the ramp sees the final quotient.
                pos_loop_en <= 1'b1;
                left_q      <= period_q;
                err_q       <= '0;
            end else if (tick && left_q != '0) begin
                sp_q        <= neg_q ? sp_q - quo_q - 32'(err_d >= {1'b0, period_q})
                                     : sp_q + quo_q + 32'(err_d >= {1'b0, period_q});
                err_q       <= (err_d >= {1'b0, period_q}) ? err_d - {1'b0, period_q} : err_d;
                left_q      <= left_q - 32'd1;
                loop_strobe <= 1'b1;
            end
            // RULE8 rpm entry as feedforward
            if (sync_pop && !short_cyc && new_mask[0] && submode_q != SUBMODE_CP) begin
                vel_ff <= new_mask[2] ? new_vr : '0;
            end
        end
    end

    // RULE6 references stay in raw units
    assign traj_setpoint = sp_q;

    // Status readback toward the master.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_q <= '0;
            meas_q   <= '0;
        end else begin
            status_q                  <= '0;
            status_q[STAT_IP_BIT]     <= ip_active;
            status_q[STAT_TARGET_BIT] <= (left_q == '0) && !div_busy_q;
            meas_q                    <= meas_pos;
        end
    end

    assign link.obj_ready    = ready_q;
    assign link.status_word  = status_q;
    assign link.mode_display = mode_q;
    assign link.meas_pos     = meas_q;
    assign link.setpoint     = sp_q;
endmodule // ip_drive

// ---- src/ip_pkg.sv ----
// ****************************************************************
// Constants shared by the drive end and the master end.
// ****************************************************************
package ip_pkg;
    // Object dictionary indices and record sub-indices.
    localparam logic [15:0] IDX_CONTROL   = 16'h6040;
    localparam logic [15:0] IDX_STATUS    = 16'h6041;
    localparam logic [15:0] IDX_QSTOP     = 16'h605a;
    localparam logic [15:0] IDX_MODE_SEL  = 16'h6060;
    localparam logic [15:0] IDX_MODE_DISP = 16'h6061;
    localparam logic [15:0] IDX_MEAS_POS  = 16'h6063;
    localparam logic [15:0] IDX_SUBMODE   = 16'h60c0;
    localparam logic [15:0] IDX_RECORD    = 16'h60c1;
    localparam logic [15:0] IDX_CYCLE     = 16'h1006;
    localparam logic [7:0]  SUB_COUNT     = 8'h00;
    localparam logic [7:0]  SUB_POS       = 8'h01;
    localparam logic [7:0]  SUB_VEL_CNT   = 8'h02;
    localparam logic [7:0]  SUB_VEL_RPM   = 8'h03;
    localparam logic [31:0] REC_ENTRIES   = 32'h0000_0003;
    // Mode and sub-mode encodings.
    localparam logic [7:0]  MODE_IP       = 8'h07;
    localparam logic [15:0] SUBMODE_LIN   = 16'h0000;
    localparam logic [15:0] SUBMODE_CPV   = 16'hffff;
    localparam logic [15:0] SUBMODE_CP    = 16'hfffe;
    localparam logic [15:0] SUBMODE_RESET = 16'h0000;
    // Control and status bit positions.
    localparam int CTRL_IP_EN_BIT  = 4;
    localparam int STAT_TARGET_BIT = 10;
    localparam int STAT_IP_BIT     = 12;
    // Timing: cycle split and the microsecond tick.
    localparam logic [31:0] CYCLE_SPLIT_US = 32'd2500;
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CLKS     = TICK_NS / CLK_PERIOD_NS;
    localparam int DIV_STEPS     = 32;
    // Set-point buffer shape.
    localparam int REC_W      = 99;
    localparam int FIFO_DEPTH = 16;
    // Master register word addresses and fields.
    localparam logic [2:0] REG_OBJ_ADDR = 3'h0;
    localparam logic [2:0] REG_OBJ_DATA = 3'h1;
    localparam logic [2:0] REG_GO       = 3'h2;
    localparam logic [2:0] REG_STATUS   = 3'h3;
    localparam logic [2:0] REG_MEAS     = 3'h4;
    localparam logic [2:0] REG_SETPOINT = 3'h5;
    localparam int GO_SEND_BIT = 0;
    localparam int GO_LAST_BIT = 1;
    localparam int GO_SYNC_BIT = 2;
endpackage

// ---- src/ip_link_if.sv ----
`timescale 1ns/1ps
// ****************************************************************
// Link between the set-point master and the drive.
// ****************************************************************
interface ip_link_if;
    logic        obj_valid;
    logic        obj_ready;
    logic [15:0] obj_index;
    logic [7:0]  obj_sub;
    logic [31:0] obj_data;
    logic        obj_last;
    logic        sync;
    logic [15:0] status_word;
    logic [7:0]  mode_display;
    logic [31:0] meas_pos;
    logic [31:0] setpoint;

    modport drive (
        input  obj_valid, obj_index, obj_sub, obj_data, obj_last, sync,
        output obj_ready, status_word, mode_display, meas_pos, setpoint
    );
    modport master (
        output obj_valid, obj_index, obj_sub, obj_data, obj_last, sync,
        input  obj_ready, status_word, mode_display, meas_pos, setpoint
    );
endinterface // ip_link_if

// ---- src/ip_master.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Master end: Avalon-MM registers drive object writes and sync.
// ****************************************************************
module ip_master (
    input  wire logic        clk,
    input  wire logic        rst_n,
    ip_link_if.master        link,
    input  wire logic [2:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [3:0]  byteenable,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest
);
    import ip_pkg::*;

    typedef enum {ST_IDLE, ST_SEND, ST_ACK} state_e;
    state_e      state_q;
    logic [31:0] addr_reg_q, data_reg_q;
    logic        valid_q, last_q, sync_q;

    // Byte-lane merge of a write into a register.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // RULE9 record first, then sync
    // Bus answer and link sequencing; waitrequest falls for exactly one edge per request.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q     <= ST_IDLE;
            waitrequest <= 1'b1;
            readdata    <= '0;
            addr_reg_q  <= '0;
            data_reg_q  <= '0;
            valid_q     <= 1'b0;
            last_q      <= 1'b0;
            sync_q      <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (write && address == REG_GO && byteenable[0]
                        && writedata[GO_SEND_BIT]) begin
                        valid_q <= 1'b1;
                        last_q  <= writedata[GO_LAST_BIT];
                        state_q <= ST_SEND;
                    end else if (read || write) begin
                        if (write && address == REG_OBJ_ADDR) begin
                            addr_reg_q <= merge(addr_reg_q, writedata, byteenable);
                        end
                        if (write && address == REG_OBJ_DATA) begin
                            data_reg_q <= merge(data_reg_q, writedata, byteenable);
                        end
                        if (write && address == REG_GO && byteenable[0]) begin
                            sync_q <= writedata[GO_SYNC_BIT];
                        end
                        case (address)
                            REG_OBJ_ADDR: readdata <= addr_reg_q;
                            REG_OBJ_DATA: readdata <= data_reg_q;
                            REG_STATUS:   readdata <= {8'h00, link.mode_display,
                                                       link.status_word};
                            REG_MEAS:     readdata <= link.meas_pos;
                            REG_SETPOINT: readdata <= link.setpoint;
                            default:      readdata <= '0;
                        endcase
                        waitrequest <= 1'b0;
                        state_q     <= ST_ACK;
                    end
                end
                ST_SEND: begin
                    // Link back-pressure stalls the bus write until the drive takes the item.
                    if (link.obj_ready) begin
                        valid_q     <= 1'b0;
                        readdata    <= '0;
                        waitrequest <= 1'b0;
                        state_q     <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    waitrequest <= 1'b1;
                    sync_q      <= 1'b0;
                    state_q     <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign link.obj_valid = valid_q;
    assign link.obj_index = addr_reg_q[15:0];
    assign link.obj_sub   = addr_reg_q[23:16];
    assign link.obj_data  = data_reg_q;
    assign link.obj_last  = last_q;
    assign link.sync      = sync_q;
endmodule // ip_master

// ---- sim/ip_link_checker.sv ----
`timescale 1ns/1ps
// ********************
// Link protocol checks.
// ********************
module ip_link_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        obj_valid,
    input wire logic        obj_ready,
    input wire logic [15:0] obj_index,
    input wire logic [7:0]  obj_sub,
    input wire logic [31:0] obj_data,
    input wire logic        obj_last,
    input wire logic        sync,
    input wire logic [15:0] status_word,
    input wire logic [7:0]  mode_display
);
    import ip_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // An offer not yet taken, and the same offer held one cycle later.
    sequence s_wait;
        obj_valid && !obj_ready;
    endsequence
    sequence s_held;
        obj_valid && $stable(obj_index) && $stable(obj_sub) && $stable(obj_data)
            && $stable(obj_last);
    endsequence
    a_offer_held: assert property (s_wait |=> s_held)
        else $error("object offer changed before acceptance");
    a_offer_drops: assert property (obj_valid && obj_ready |=> !obj_valid)
        else $error("object offer stayed after acceptance");
    a_offer_gap: assert property ($fell(obj_valid) |-> !obj_valid [*2])
        else $error("object offers too close together");
    a_sync_single: assert property (sync |=> !sync)
        else $error("sync longer than one cycle");
    a_sync_alone: assert property (sync |-> !obj_valid)
        else $error("sync during an object offer");
    a_status_bits: assert property ((status_word & 16'hebff) == 16'h0000)
        else $error("unused status bits set");
    a_active_mode: assert property (status_word[STAT_IP_BIT] |-> $past(mode_display) == MODE_IP)
        else $error("mode active flag without mode");
    a_ready_wakes: assert property ($rose(rst_n) |-> ##[0:2] obj_ready)
        else $error("drive not ready after reset");
endmodule // ip_link_checker

// ---- sim/interpolated_position_mode_tb.sv ----
`timescale 1ns/1ps
// ********************
// Bench for both ends of the set-point link.
// ********************
module interpolated_position_mode_tb;
    import ip_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  address = 3'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] meas_pos = 32'h1234_5678;
    logic [31:0] readdata, traj_setpoint, vel_cmd, vel_ff, q;
    logic        waitrequest, pos_loop_en, vel_is_rpm;
    logic        ff_en = 1'b1;
    int          errors = 0;
    int          comparisons = 0;
    // Rows: position sent, feedforward expected.
    logic [31:0] rows [4][2] = '{'{32'h64, 32'h64}, '{32'h15e, 32'hfa},
        '{32'hffffffce, 32'hfffffe70}, '{32'h7fffffff, 32'h80000031}};
    ip_link_if link ();
    ip_master ip_master_inst (.clk(clk), .rst_n(rst_n), .link(link), .address(address),
        .read(read), .write(write), .byteenable(4'hf), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest));
    ip_drive ip_drive_inst (.clk(clk), .rst_n(rst_n), .link(link), .meas_pos(meas_pos),
        .ff_compute_en(ff_en), .traj_setpoint(traj_setpoint), .pos_loop_en(pos_loop_en),
        .vel_cmd(vel_cmd), .vel_is_rpm(vel_is_rpm), .vel_ff(vel_ff), .loop_strobe(),
        .quick_stop_mode());
    ip_link_checker chk_inst (.clk(clk), .rst_n(rst_n), .obj_valid(link.obj_valid),
        .obj_ready(link.obj_ready), .obj_index(link.obj_index), .obj_sub(link.obj_sub),
        .obj_data(link.obj_data), .obj_last(link.obj_last), .sync(link.sync),
        .status_word(link.status_word), .mode_display(link.mode_display));
    // Clock of 20 ns.
    always #10 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One bus cycle, held until waitrequest is seen low.
    task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
        @(posedge clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wobj(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                        input logic l);
        av(1'b1, REG_OBJ_ADDR, {8'h00, s, i});
        av(1'b1, REG_OBJ_DATA, d);
        av(1'b1, REG_GO, {30'h0, l, 1'b1});
    endtask
    task automatic fire;
        av(1'b1, REG_GO, 32'h4);
        repeat (3) @(posedge clk);
    endtask
    task automatic close_out;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence of tests.
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        wobj(IDX_MODE_SEL, SUB_COUNT, 32'h7, 1'b0);
        wobj(IDX_CONTROL, SUB_COUNT, 32'h10, 1'b0);
        av(1'b0, REG_STATUS, 32'h0);
        chk("status", q & 32'h00ff_1000, 32'h0007_1000);
        av(1'b0, REG_MEAS, 32'h0);
        chk("meas", q, 32'h1234_5678);
        av(1'b0, 3'h7, 32'h0);
        chk("unmapped", q, 32'h0);
        $display("test setup done");
        foreach (rows[r]) begin
            wobj(IDX_RECORD, SUB_POS, rows[r][0], 1'b1);
            fire;
            chk("setpoint", traj_setpoint, rows[r][0]);
            chk("vel_ff", vel_ff, rows[r][1]);
        end
        av(1'b0, REG_SETPOINT, 32'h0);
        chk("link setpoint", q, rows[3][0]);
        $display("test rows done");
        wobj(IDX_RECORD, SUB_VEL_RPM, 32'h4d2, 1'b1);
        fire;
        chk("loop_en", {31'h0, pos_loop_en}, 32'h0);
        chk("vel_cmd", vel_cmd, 32'h4d2);
        chk("rpm", {31'h0, vel_is_rpm}, 32'h1);
        wobj(IDX_RECORD, SUB_VEL_CNT, 32'h10, 1'b0);
        wobj(IDX_RECORD, SUB_VEL_RPM, 32'h20, 1'b1);
        fire;
        chk("vel_cmd", vel_cmd, 32'h10);
        chk("rpm", {31'h0, vel_is_rpm}, 32'h0);
        $display("test velocity done");
        for (int k = 1; k <= 15; k++)
            wobj(IDX_RECORD, SUB_POS, 32'(k), 1'b1);
        @(posedge clk);
        chk("full", {31'h0, link.obj_ready}, 32'h0);
        ff_en <= 1'b0;
        for (int k = 1; k <= 16; k++) begin
            fire;
            chk("drain", traj_setpoint, 32'(k > 15 ? 15 : k));
        end
        chk("loop_en", {31'h0, pos_loop_en}, 32'h1);
        chk("ff off", vel_ff, 32'h0);
        $display("test buffer done");
        wobj(IDX_CYCLE, SUB_COUNT, CYCLE_SPLIT_US, 1'b0);
        wobj(IDX_RECORD, SUB_VEL_RPM, 32'h77, 1'b0);
        wobj(IDX_RECORD, SUB_POS, 32'h1f, 1'b1);
        fire;
        chk("long hold", traj_setpoint, 32'hf);
        chk("rpm ff", vel_ff, 32'h77);
        repeat (40) @(posedge clk);
        av(1'b0, REG_STATUS, 32'h0);
        chk("ramping", q & 32'h400, 32'h0);
        $display("test long cycle done");
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("reset", traj_setpoint, 32'h0);
        $display("test reset done");
        close_out;
    end
    // Watchdog against a hang.
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out;
    end
endmodule // interpolated_position_mode_tb
